// *** hw/servo_homing_sequencer.sv ***
// Homing sequencer with AHB-Lite register slave
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`default_nettype none
// How it works
// - Modes 26-30: home switch is origin and slowdown
// - Mode 26: fast forward, rise slow, stop fall
// - Mode 26 forward limit: fast reverse, same ending
// - Modes 26/27 switch high: slow forward, stop fall
// - Mode 27: fast reverse, limit flips, stop fall
// - Mode 28: rise slow forward, fall slow reverse
// - Mode 28 switch high: forward, fall reverse, rise stop
// - Mode 29: rise slow reverse, fall slow forward
// - Mode 29 switch high: reverse, fall forward, rise stop
// - Mode 30: fast reverse, rise slow reverse, fall stop
// - Mode 30 switch high: slow reverse, stop fall
// - Mode 33: slow reverse, stop first index
// - Mode 34: slow forward, stop first index
// - Mode 35: origin here, status 0x00 to 0x01/0x02
// - Mode 35 then multiturn reset per compensation
module servo_homing_sequencer (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Async reset
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write
   input wire logic [2:0] hsize, // Size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Response
   input wire logic home_switch, // Home switch level
   input wire logic fwd_limit, // Forward limit switch
   input wire logic rev_limit, // Reverse limit switch
   input wire logic index_pulse, // Encoder index
   output logic motion_run, // Motion enabled
   output logic motion_fwd, // Direction forward
   output logic motion_fast, // High speed
   output logic origin_set, // Take position as origin
   output logic multiturn_reset_operation, // Multiturn reset
   output logic [7:0] homing_status_field // Homing status
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FAST,
      ST_SLOW1,
      ST_SLOW2,
      ST_INDEX,
      ST_ORIGIN
   } state_t;

   ////////////////////////////////////////////////////////////////
   // Input synchroniser and edge detection
   localparam int W = homing_pkg::IN_W;
   logic [W-1:0] sync1_q;
   logic [W-1:0] sync2_q;
   logic [W-1:0] prev_q;
   wire [W-1:0] raw_in = {index_pulse, rev_limit, fwd_limit,
      home_switch};
   wire [W-1:0] rise_w = sync2_q & ~prev_q;
   wire [W-1:0] fall_w = ~sync2_q & prev_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   wire home_lvl = sync2_q[homing_pkg::IN_HOME];
   wire home_rise = rise_w[homing_pkg::IN_HOME];
   wire home_fall = fall_w[homing_pkg::IN_HOME];
   wire index_rise = rise_w[homing_pkg::IN_INDEX];
   wire flim_lvl = sync2_q[homing_pkg::IN_FLIM];
   wire rlim_lvl = sync2_q[homing_pkg::IN_RLIM];

   ////////////////////////////////////////////////////////////////
   // AHB-Lite slave
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic start_q;
   logic abort_q;
   logic [5:0] mode_q;
   logic ocomp_q;
   logic bad_q;
   logic fault_q;
   logic [7:0] hstat_q;
   state_t state_q;

   wire addr_ok = hsel & htrans[1] & hready;
   wire wr_ctrl = wr_pend_q & (wr_addr_q == homing_pkg::CTRL_OFS);
   wire wr_cfg = wr_pend_q & (wr_addr_q == homing_pkg::CFG_OFS);
   wire busy = (state_q != ST_IDLE);
   wire [31:0] ctrl_rd = {18'h0,
      mode_q, 8'h0};
   wire [31:0] cfg_rd = {31'h0, ocomp_q};
   wire [31:0] stat_rd = {16'h0, sync2_q, 1'b0, fault_q, bad_q, busy,
      hstat_q};
   wire [7:0] rd_addr = haddr[7:0];
   wire [31:0] rd_mux =
      (rd_addr == homing_pkg::CTRL_OFS) ? ctrl_rd :
      (rd_addr == homing_pkg::CFG_OFS) ? cfg_rd :
      (rd_addr == homing_pkg::STAT_OFS) ? stat_rd : 32'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h0;
      end else begin
         wr_pend_q <= addr_ok & hwrite;
         wr_addr_q <= haddr[7:0];
         hrdata_q <= (addr_ok & ~hwrite) ? rd_mux : 32'h0;
      end
   end

   // Start and abort pulses act one cycle after the write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_q <= 1'b0;
         abort_q <= 1'b0;
         mode_q <= homing_pkg::MODE_RST;
         ocomp_q <= homing_pkg::OCOMP_RST;
      end else begin
         start_q <= wr_ctrl & hwdata[homing_pkg::START_BIT];
         abort_q <= wr_ctrl & hwdata[homing_pkg::ABORT_BIT];
         if (wr_ctrl && !busy) begin
            mode_q <= hwdata[homing_pkg::MODE_LSB +: homing_pkg::MODE_W];
         end
         if (wr_cfg) begin
            ocomp_q <= hwdata[homing_pkg::OCOMP_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Mode decode
   wire is_sw_mode = (mode_q >= homing_pkg::MODE_26) &&
      (mode_q <= homing_pkg::MODE_30);
   wire fast_fwd = (mode_q == homing_pkg::MODE_26);
   wire slow_fwd = (mode_q <= homing_pkg::MODE_28);
   wire two_phase = (mode_q == homing_pkg::MODE_28) ||
      (mode_q == homing_pkg::MODE_29);
   wire limit_ahead = motion_fwd ? flim_lvl : rlim_lvl;

   ////////////////////////////////////////////////////////////////
   // Homing state machine
   state_t state_d;
   logic run_q;
   logic run_d;
   logic fwd_q;
   logic fwd_d;
   logic fast_q;
   logic fast_d;
   logic flip_q;
   logic flip_d;
   logic org_q;
   logic org_d;
   logic mt_q;
   logic mt_d;
   logic bad_d;
   logic fault_d;
   logic [7:0] hstat_d;

   always_comb begin
      state_d = state_q;
      run_d = run_q;
      fwd_d = fwd_q;
      fast_d = fast_q;
      flip_d = flip_q;
      org_d = 1'b0;
      mt_d = 1'b0;
      bad_d = bad_q;
      fault_d = fault_q;
      hstat_d = hstat_q;
      case (state_q)
         ST_IDLE: begin
            if (start_q) begin
               hstat_d = homing_pkg::HSTAT_IDLE;
               bad_d = 1'b0;
               fault_d = 1'b0;
               flip_d = 1'b0;
               if (is_sw_mode && home_lvl) begin
                  state_d = ST_SLOW1;
                  fwd_d = slow_fwd;
                  fast_d = 1'b0;
                  run_d = 1'b1;
               end else if (is_sw_mode) begin
                  state_d = ST_FAST;
                  fwd_d = fast_fwd;
                  fast_d = 1'b1;
                  run_d = 1'b1;
               end else if (mode_q == homing_pkg::MODE_33 ||
                            mode_q == homing_pkg::MODE_34) begin
                  state_d = ST_INDEX;
                  fwd_d = (mode_q == homing_pkg::MODE_34);
                  fast_d = 1'b0;
                  run_d = 1'b1;
               end else if (mode_q == homing_pkg::MODE_35) begin
                  state_d = ST_ORIGIN;
                  org_d = 1'b1;
               end else begin
                  bad_d = 1'b1;
               end
            end
         end
         ST_FAST: begin
            if (home_rise) begin
               state_d = ST_SLOW1;
               fwd_d = slow_fwd;
               fast_d = 1'b0;
            end else if (limit_ahead && !flip_q) begin
               fwd_d = ~fwd_q;
               flip_d = 1'b1;
            end else if (limit_ahead && flip_q) begin
               // Both limits hit without a home switch: give up
               state_d = ST_IDLE;
               run_d = 1'b0;
               fault_d = 1'b1;
            end
         end
         ST_SLOW1: begin
            if (home_fall && two_phase) begin
               state_d = ST_SLOW2;
               fwd_d = ~fwd_q;
            end else if (home_fall) begin
               state_d = ST_IDLE;
               run_d = 1'b0;
               hstat_d = homing_pkg::HSTAT_DONE;
            end
         end
         ST_SLOW2: begin
            if (home_rise) begin
               state_d = ST_IDLE;
               run_d = 1'b0;
               hstat_d = homing_pkg::HSTAT_DONE;
            end
         end
         ST_INDEX: begin
            if (index_rise) begin
               state_d = ST_IDLE;
               run_d = 1'b0;
               hstat_d = homing_pkg::HSTAT_DONE;
            end
         end
         ST_ORIGIN: begin
            state_d = ST_IDLE;
            if (ocomp_q) begin
               mt_d = 1'b1;
               hstat_d = homing_pkg::HSTAT_DONE_MT;
            end else begin
               hstat_d = homing_pkg::HSTAT_DONE;
            end
         end
         default: begin
            state_d = ST_IDLE;
            run_d = 1'b0;
         end
      endcase
      if (abort_q && state_q != ST_IDLE) begin
         state_d = ST_IDLE;
         run_d = 1'b0;
         org_d = 1'b0;
         mt_d = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
         run_q <= 1'b0;
         fwd_q <= 1'b0;
         fast_q <= 1'b0;
         flip_q <= 1'b0;
         org_q <= 1'b0;
         mt_q <= 1'b0;
         bad_q <= 1'b0;
         fault_q <= 1'b0;
         hstat_q <= homing_pkg::HSTAT_IDLE;
      end else begin
         state_q <= state_d;
         run_q <= run_d;
         fwd_q <= fwd_d;
         fast_q <= fast_d;
         flip_q <= flip_d;
         org_q <= org_d;
         mt_q <= mt_d;
         bad_q <= bad_d;
         fault_q <= fault_d;
         hstat_q <= hstat_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs, all straight from flip-flops
   logic hreadyout_q;
   logic hresp_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b0;
         hresp_q <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign motion_run = run_q;
   assign motion_fwd = fwd_q;
   assign motion_fast = fast_q;
   assign origin_set = org_q;
   assign multiturn_reset_operation = mt_q;
   assign homing_status_field = hstat_q;

endmodule // servo_homing_sequencer
`default_nettype wire

// *** shared/homing_pkg.sv ***
// Register map, field positions and codes of the homing sequencer
`default_nettype none
package homing_pkg;
   ////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CFG_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   ////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int START_BIT = 0;
   localparam int ABORT_BIT = 1;
   localparam int MODE_LSB = 8;
   localparam int MODE_W = 6;
   localparam logic [5:0] MODE_RST = 6'h00;
   // Config register fields
   localparam int OCOMP_BIT = 0;
   localparam logic OCOMP_RST = 1'b0;
   // Status register fields
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_BAD_BIT = 9;
   localparam int STAT_FAULT_BIT = 10;
   localparam int STAT_SW_LSB = 12;
   ////////////////////////////////////////////////////////////////
   // Homing mode codes
   localparam logic [5:0] MODE_26 = 6'h1A;
   localparam logic [5:0] MODE_27 = 6'h1B;
   localparam logic [5:0] MODE_28 = 6'h1C;
   localparam logic [5:0] MODE_29 = 6'h1D;
   localparam logic [5:0] MODE_30 = 6'h1E;
   localparam logic [5:0] MODE_33 = 6'h21;
   localparam logic [5:0] MODE_34 = 6'h22;
   localparam logic [5:0] MODE_35 = 6'h23;
   ////////////////////////////////////////////////////////////////
   // Homing status field codes
   localparam logic [7:0] HSTAT_IDLE = 8'h00;
   localparam logic [7:0] HSTAT_DONE = 8'h01;
   localparam logic [7:0] HSTAT_DONE_MT = 8'h02;
   // Synchronised input vector positions
   localparam int IN_HOME = 0;
   localparam int IN_FLIM = 1;
   localparam int IN_RLIM = 2;
   localparam int IN_INDEX = 3;
   localparam int IN_W = 4;
endpackage
`default_nettype wire

// *** verif/axis_model.sv ***
// Axis model: position, switches and index
`default_nettype none
module axis_model (
   input wire logic hclk, // Clock
   input wire logic load, // Load position
   input wire logic [15:0] load_pos, // New position
   input wire logic run, // Move
   input wire logic fwd, // Forward
   input wire logic fast, // Fast
   output logic [15:0] pos, // Position
   output logic home, // Home switch
   output logic flim, // Forward limit
   output logic rlim, // Reverse limit
   output logic index // Index mark
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] step;
   assign step = fast ? 16'h0004 : 16'h0001;
   always_ff @(posedge hclk) begin
      if (load) pos <= load_pos;
      else if (run) pos <= fwd ? pos + step : pos - step;
   end
   assign home = pos >= 16'h01E0 && pos <= 16'h0208;
   assign flim = pos >= 16'h0384;
   assign rlim = pos <= 16'h0064;
   // Two positions wide so slow motion holds it two cycles
   assign index = pos[5:1] == 5'h00;
endmodule // axis_model
`default_nettype wire

// *** verif/homing_chk.sv ***
// Port checker for the homing sequencer
`default_nettype none
module homing_chk (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset
   input wire logic hsel, // Select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer
   input wire logic hwrite, // Write
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Ready
   input wire logic [31:0] hrdata, // Read data
   input wire logic hreadyout, // Slave ready
   input wire logic home_switch, // Home level
   input wire logic motion_run, // Run
   input wire logic motion_fwd, // Forward
   input wire logic motion_fast, // Fast
   input wire logic origin_set // Origin pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic act;
   logic wr_q;
   logic rd_q;
   logic go_q;
   logic [5:0] m_q;
   logic [2:0] cmd;
   assign act = hsel && htrans[1] && hready;
   assign cmd = {motion_run, motion_fwd, motion_fast};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         go_q <= 1'b0;
         m_q <= 6'h00;
      end else begin
         wr_q <= act && hwrite && haddr[7:0] == homing_pkg::CTRL_OFS;
         rd_q <= act && !hwrite;
         go_q <= wr_q && hwdata[homing_pkg::START_BIT];
         if (wr_q) m_q <= hwdata[homing_pkg::MODE_LSB +: homing_pkg::MODE_W];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////
   a_ready_zero: assert property ($past(hresetn) |-> hreadyout)
      else $error("wait state seen");
   a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0)
      else $error("read data outside data phase");
   a_m26_start: assert property (go_q && m_q == 6'h1A && !home_switch
      |-> ##2 cmd == 3'h7) else $error("mode 26 start wrong");
   a_m27_start: assert property (go_q && m_q == 6'h1B && !home_switch
      |-> ##2 cmd == 3'h5) else $error("mode 27 start wrong");
   a_hw_fwd: assert property (go_q && home_switch && m_q inside
      {6'h1A, 6'h1B, 6'h1C} |-> ##2 cmd == 3'h6) else $error("slow fwd");
   a_hw_rev: assert property (go_q && home_switch && m_q inside
      {6'h1D, 6'h1E} |-> ##2 cmd == 3'h4) else $error("slow rev");
   a_index_rev: assert property (go_q && m_q == 6'h21
      |-> ##2 cmd == 3'h4) else $error("mode 33 start wrong");
   a_index_fwd: assert property (go_q && m_q == 6'h22
      |-> ##2 cmd == 3'h6) else $error("mode 34 start wrong");
   a_origin_pulse: assert property (go_q && m_q == 6'h23
      |-> ##[1:3] origin_set) else $error("no origin pulse");
   a_slow_stays: assert property (motion_run && !motion_fast
      |=> !motion_fast) else $error("fast after slow");
endmodule // homing_chk
bind servo_homing_sequencer homing_chk u_chk (.hclk, .hresetn, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout,
   .home_switch, .motion_run, .motion_fwd, .motion_fast, .origin_set);
`default_nettype wire

// *** verif/servo_homing_sequencer_tb_top.sv ***
// Testbench for the homing sequencer
`default_nettype none
module servo_homing_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [5:0] md;
      logic [15:0] sp;
      logic [2:0] cmd;
      logic [15:0] ep;
      logic dr;
   } row_t;
   row_t rows [17] = '{
      '{6'h1A, 16'h00C8, 3'h7, 16'h0209, 1'b1},
      '{6'h1A, 16'h0258, 3'h7, 16'h0209, 1'b1},
      '{6'h1A, 16'h01F4, 3'h6, 16'h0209, 1'b1},
      '{6'h1B, 16'h00C8, 3'h5, 16'h0209, 1'b1},
      '{6'h1B, 16'h0258, 3'h5, 16'h0209, 1'b1},
      '{6'h1B, 16'h01F4, 3'h6, 16'h0209, 1'b1},
      '{6'h1C, 16'h00C8, 3'h5, 16'h0208, 1'b0},
      '{6'h1C, 16'h0258, 3'h5, 16'h0208, 1'b0},
      '{6'h1C, 16'h01F4, 3'h6, 16'h0208, 1'b0},
      '{6'h1D, 16'h00C8, 3'h5, 16'h01E0, 1'b1},
      '{6'h1D, 16'h0258, 3'h5, 16'h01E0, 1'b1},
      '{6'h1D, 16'h01F4, 3'h4, 16'h01E0, 1'b1},
      '{6'h1E, 16'h00C8, 3'h5, 16'h01DF, 1'b0},
      '{6'h1E, 16'h0258, 3'h5, 16'h01DF, 1'b0},
      '{6'h1E, 16'h01F4, 3'h4, 16'h01DF, 1'b0},
      '{6'h21, 16'h012C, 3'h4, 16'h0101, 1'b0},
      '{6'h22, 16'h012C, 3'h6, 16'h0140, 1'b1}};
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, load;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] load_pos, pos, e;
   logic home_switch, fwd_limit, rev_limit, index_pulse;
   logic motion_run, motion_fwd, motion_fast, origin_set, mt;
   logic [7:0] hsf;
   int n_errors, samples_checked, n_org, n_mt, k;
   assign hready = hreadyout;
   servo_homing_sequencer DUT (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
      .home_switch, .fwd_limit, .rev_limit, .index_pulse, .motion_run,
      .motion_fwd, .motion_fast, .origin_set,
      .multiturn_reset_operation(mt), .homing_status_field(hsf));
   axis_model m0 (.hclk, .load, .load_pos, .run(motion_run),
      .fwd(motion_fwd), .fast(motion_fast), .pos, .home(home_switch),
      .flim(fwd_limit), .rlim(rev_limit), .index(index_pulse));
   ////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("wrong value at %0t: %h vs %h", $time, seen, exp);
         n_errors++;
      end
   endtask
   task final_report;
      if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task start(input logic [15:0] p, input logic [5:0] m);
      load <= 1'b1;
      load_pos <= p;
      @(posedge hclk);
      load <= 1'b0;
      repeat (4) @(posedge hclk);
      xfer(homing_pkg::CTRL_OFS, 1'b1, {18'h0, m, 8'h01});
   endtask
   always @(posedge hclk) begin
      if (origin_set === 1'b1) n_org++;
      if (mt === 1'b1) n_mt++;
   end
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      repeat (60000) @(posedge hclk);
      n_errors++;
      final_report;
   end
   initial begin
      hresetn <= 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} <= '0;
      hsize <= 3'h2;
      load <= 1'b1;
      load_pos <= 16'h00C8;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      load <= 1'b0;
      repeat (2) @(posedge hclk);
      for (int i = 0; i < 4; i++) begin
         xfer(8'(i * 4), 1'b0, 32'h0);
         check(rd, 32'h0);
         check(hresp, 1'b0);
      end
      foreach (rows[i]) begin
         start(rows[i].sp, rows[i].md);
         k = 0;
         while (motion_run !== 1'b1 && k < 20) begin
            @(posedge hclk);
            k++;
         end
         check({motion_run, motion_fwd, motion_fast}, rows[i].cmd);
         check(hsf, homing_pkg::HSTAT_IDLE);
         while (hsf !== homing_pkg::HSTAT_DONE && k < 4000) begin
            @(posedge hclk);
            k++;
         end
         check(hsf, homing_pkg::HSTAT_DONE);
         @(posedge hclk);
         check(motion_run, 1'b0);
         e = rows[i].ep;
         check(rows[i].dr ? (pos >= e && pos <= e + 16'h8)
            : (pos <= e && pos >= e - 16'h8), 1'b1);
         xfer(homing_pkg::STAT_OFS, 1'b0, 32'h0);
         check(rd[10:0], 11'h001);
      end
      // Origin mode with and without multiturn reset
      for (int c = 0; c < 2; c++) begin
         xfer(homing_pkg::CFG_OFS, 1'b1, 32'(c));
         n_org = 0;
         n_mt = 0;
         start(16'h00C8, homing_pkg::MODE_35);
         repeat (10) @(posedge hclk);
         check(hsf, c ? 8'h02 : 8'h01);
         check(n_org, 1);
         check(n_mt, c);
      end
      // Abort in mid-run
      start(16'h00C8, homing_pkg::MODE_26);
      repeat (20) @(posedge hclk);
      xfer(homing_pkg::CTRL_OFS, 1'b1, 32'h2);
      repeat (4) @(posedge hclk);
      check(motion_run, 1'b0);
      check(hsf, homing_pkg::HSTAT_IDLE);
      // Unsupported mode
      start(16'h00C8, 6'h05);
      repeat (6) @(posedge hclk);
      check(motion_run, 1'b0);
      xfer(homing_pkg::STAT_OFS, 1'b0, 32'h0);
      check(rd[9], 1'b1);
      // Reset in mid-run
      start(16'h00C8, homing_pkg::MODE_26);
      repeat (10) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      check({motion_run, motion_fwd, motion_fast}, 3'h0);
      check(hsf, homing_pkg::HSTAT_IDLE);
      hresetn <= 1'b1;
      @(posedge hclk);
      check(hreadyout, 1'b0);
      @(posedge hclk);
      check(hreadyout, 1'b1);
      xfer(homing_pkg::STAT_OFS, 1'b0, 32'h0);
      check(rd[10:0], 11'h000);
      final_report;
   end
endmodule // servo_homing_sequencer_tb_top
`default_nettype wire
